// *** rpc_regs.vh ***
// register offsets, field positions and reset values of the upper configuration bank
`ifndef RPC_REGS_VH
`define RPC_REGS_VH

// ----------------------------------------
// offsets
// ----------------------------------------
`define RPC_ADDR_PIPE3_WIDTH   5'h14
`define RPC_ADDR_PIPE4_WIDTH   5'h15
`define RPC_ADDR_PIPE5_WIDTH   5'h16
`define RPC_ADDR_QUEUE_FLAGS   5'h17
`define RPC_ADDR_VARLEN_EN     5'h1c
`define RPC_ADDR_PROTO_OPTS    5'h1d
`define RPC_ADDR_TIMING        5'h1e
`define RPC_ADDR_GUARD_CTL     5'h1f

// ----------------------------------------
// field positions
// ----------------------------------------
`define RPC_QF_TX_REUSE        6
`define RPC_QF_TX_FULL         5
`define RPC_QF_TX_EMPTY        4
`define RPC_QF_RX_FULL         1
`define RPC_QF_RX_EMPTY        0
`define RPC_OPT_GLOBAL_VARLEN  2
`define RPC_OPT_ACK_PAYLOAD    1
`define RPC_OPT_NOACK_CMD      0
`define RPC_GRD_CE_OVERRIDE    15
`define RPC_GRD_ENABLE         4

// ----------------------------------------
// reset values and the largest payload width
// ----------------------------------------
`define RPC_RST_PIPE_WIDTH     6'h00
`define RPC_RST_VARLEN_EN      6'h00
`define RPC_RST_PROTO_OPTS     3'h0
`define RPC_RST_LNA_WAIT       8'h00
`define RPC_RST_BANDGAP_WAIT   8'h10
`define RPC_RST_RX_TIMEOUT     8'h80
`define RPC_RST_TX_SETUP       8'h32
`define RPC_RST_RX_SETUP       8'h28
`define RPC_RST_GUARD_CTL      16'h0032
`define RPC_MAX_PAYLOAD        6'h20

// ----------------------------------------
// timing
// ----------------------------------------
`define RPC_CLK_MHZ            100
`define RPC_US_NS              1000
`define RPC_CLK_NS             10
`define RPC_CYC_PER_US         (`RPC_US_NS / `RPC_CLK_NS)

`endif

// *** rpc_us_timer.v ***
// microsecond-scaled countdown timer for mode transition waits
`timescale 1ns/1ps
`default_nettype none
`include "rpc_regs.vh"

module rpc_us_timer #(
  parameter CYC_PER_US = `RPC_CYC_PER_US
) (
  // clock and reset
  input  wire       mclk,
  input  wire       reset_n,
  // control
  input  wire       start,
  input  wire [7:0] count_us,
  // status
  output reg        busy,
  output reg        done
);

  reg [7:0]  us_left_reg;
  reg [15:0] tick_reg;

  always @(posedge mclk) begin
    if (!reset_n) begin
      us_left_reg <= 8'h00;
      tick_reg    <= 16'h0000;
      busy        <= 1'b0;
      done        <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        // a zero count finishes at once
        us_left_reg <= count_us;
        tick_reg    <= 16'h0000;
        busy        <= (count_us != 8'h00);
        done        <= (count_us == 8'h00);
      end else if (busy) begin
        if (tick_reg == CYC_PER_US[15:0] - 16'h0001) begin
          tick_reg <= 16'h0000;
          if (us_left_reg == 8'h01) begin
            busy <= 1'b0;
            done <= 1'b1;
          end
          us_left_reg <= us_left_reg - 8'h01;
        end else begin
          tick_reg <= tick_reg + 16'h0001;
        end
      end
    end
  end

endmodule // rpc_us_timer
`default_nettype wire

// *** rpc_config_regs.v ***
// upper configuration register bank of the packet radio protocol engine
`timescale 1ns/1ps
`default_nettype none
`include "rpc_regs.vh"

module rpc_config_regs #(
  parameter NUM_PIPES  = 6,
  parameter CYC_PER_US = `RPC_CYC_PER_US
) (
  // clock and reset
  input  wire        mclk,
  input  wire        reset_n,
  // register port, one byte per access
  input  wire [4:0]  reg_addr,
  input  wire [2:0]  reg_byte,
  input  wire        reg_wr,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_rd,
  output reg  [7:0]  reg_rdata,
  // queue status from the fifos
  input  wire        tx_payload_reuse_flag,
  input  wire        tx_queue_full,
  input  wire        tx_queue_empty,
  input  wire        rx_queue_full,
  input  wire        rx_queue_empty,
  // command and mode requests from the engine
  input  wire        write_payload_without_ack_cmd,
  input  wire        start_tx_setup,
  input  wire        start_rx_setup,
  input  wire        start_rx_timeout,
  input  wire        start_bandgap_wait,
  input  wire        chip_enable_pin,
  // configuration outputs
  output wire [5:0]  pipe3_width,
  output wire [5:0]  pipe4_width,
  output wire [5:0]  pipe5_width,
  output wire [5:0]  pipe3_5_unused,
  output reg  [5:0]  pipe_varlen_active,
  output wire        global_varlen_en,
  output wire        ack_payload_en,
  output wire        noack_cmd_en,
  output reg         noack_cmd_accept,
  output reg         noack_cmd_reject,
  output wire [7:0]  lna_wait_cycles,
  output wire [7:0]  bandgap_wait_count,
  output wire [7:0]  rx_timeout_count,
  output wire [2:0]  tail_repeat_count,
  output wire        preguard_enable,
  output wire [4:0]  preguard_bits,
  output reg         chip_enable_eff,
  // transition timers
  output wire        tx_setup_done,
  output wire        rx_setup_done,
  output wire        rx_timeout_done,
  output wire        bandgap_done,
  output wire        setup_busy
);

  // ----------------------------------------
  // storage
  // ----------------------------------------
  reg [5:0]  pipe_width_reg [3:5];
  reg [5:0]  varlen_en_reg;
  reg [2:0]  proto_opts_reg;
  reg [39:0] timing_reg;
  reg [15:0] guard_reg;
  integer    i;

  // a value whose low six bits exceed the largest payload is clamped and bits 7:6 are dropped, so the engine never sees >32
  function [5:0] clamp_width;
    input [7:0] v;
    begin
      if (v[5:0] > `RPC_MAX_PAYLOAD) begin
        clamp_width = `RPC_MAX_PAYLOAD;
      end else begin
        clamp_width = v[5:0];
      end
    end
  endfunction

  function [7:0] byte_of;
    input [39:0] w;
    input [2:0]  b;
    begin
      case (b)
        3'h0:    byte_of = w[7:0];
        3'h1:    byte_of = w[15:8];
        3'h2:    byte_of = w[23:16];
        3'h3:    byte_of = w[31:24];
        3'h4:    byte_of = w[39:32];
        default: byte_of = 8'h00;
      endcase
    end
  endfunction

  // ----------------------------------------
  // register writes
  // ----------------------------------------
  always @(posedge mclk) begin
    if (!reset_n) begin
      for (i = 3; i <= 5; i = i + 1) begin
        pipe_width_reg[i] <= `RPC_RST_PIPE_WIDTH;
      end
      varlen_en_reg  <= `RPC_RST_VARLEN_EN;
      proto_opts_reg <= `RPC_RST_PROTO_OPTS;
      timing_reg     <= {`RPC_RST_LNA_WAIT, `RPC_RST_BANDGAP_WAIT, `RPC_RST_RX_TIMEOUT,
                         `RPC_RST_TX_SETUP, `RPC_RST_RX_SETUP};
      guard_reg      <= `RPC_RST_GUARD_CTL;
    end else if (reg_wr) begin
      if (reg_addr == `RPC_ADDR_PIPE3_WIDTH) begin
        pipe_width_reg[3] <= clamp_width(reg_wdata);
      end else if (reg_addr == `RPC_ADDR_PIPE4_WIDTH) begin
        pipe_width_reg[4] <= clamp_width(reg_wdata);
      end else if (reg_addr == `RPC_ADDR_PIPE5_WIDTH) begin
        pipe_width_reg[5] <= clamp_width(reg_wdata);
      end else if (reg_addr == `RPC_ADDR_VARLEN_EN) begin
        varlen_en_reg <= reg_wdata[5:0];
      end else if (reg_addr == `RPC_ADDR_PROTO_OPTS) begin
        proto_opts_reg <= reg_wdata[2:0];
      end else if (reg_addr == `RPC_ADDR_TIMING) begin
        case (reg_byte)
          3'h0:    timing_reg[7:0]   <= reg_wdata;
          3'h1:    timing_reg[15:8]  <= reg_wdata;
          3'h2:    timing_reg[23:16] <= reg_wdata;
          3'h3:    timing_reg[31:24] <= reg_wdata;
          3'h4:    timing_reg[39:32] <= reg_wdata;
          default: timing_reg        <= timing_reg;
        endcase
      end else if (reg_addr == `RPC_ADDR_GUARD_CTL) begin
        // bytes land lsbyte first; the queue flags register ignores writes
        if (reg_byte == 3'h0) begin
          guard_reg[7:0] <= reg_wdata;
        end else if (reg_byte == 3'h1) begin
          guard_reg[15:8] <= reg_wdata;
        end
      end
    end
  end

  // ----------------------------------------
  // register reads
  // ----------------------------------------
  always @(posedge mclk) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      if (reg_addr == `RPC_ADDR_PIPE3_WIDTH) begin
        reg_rdata <= {2'b00, pipe_width_reg[3]};
      end else if (reg_addr == `RPC_ADDR_PIPE4_WIDTH) begin
        reg_rdata <= {2'b00, pipe_width_reg[4]};
      end else if (reg_addr == `RPC_ADDR_PIPE5_WIDTH) begin
        reg_rdata <= {2'b00, pipe_width_reg[5]};
      end else if (reg_addr == `RPC_ADDR_QUEUE_FLAGS) begin
        reg_rdata <= {1'b0, tx_payload_reuse_flag, tx_queue_full, tx_queue_empty,
                      2'b00, rx_queue_full, rx_queue_empty};
      end else if (reg_addr == `RPC_ADDR_VARLEN_EN) begin
        reg_rdata <= {2'b00, varlen_en_reg};
      end else if (reg_addr == `RPC_ADDR_PROTO_OPTS) begin
        reg_rdata <= {5'h00, proto_opts_reg};
      end else if (reg_addr == `RPC_ADDR_TIMING) begin
        reg_rdata <= byte_of(timing_reg, reg_byte);
      end else if (reg_addr == `RPC_ADDR_GUARD_CTL) begin
        reg_rdata <= byte_of({24'h000000, guard_reg}, reg_byte);
      end else begin
        reg_rdata <= 8'h00;
      end
    end
  end

  // ----------------------------------------
  // derived configuration
  // ----------------------------------------
  assign pipe3_width        = pipe_width_reg[3];
  assign pipe4_width        = pipe_width_reg[4];
  assign pipe5_width        = pipe_width_reg[5];
  assign pipe3_5_unused     = {3'b000, pipe_width_reg[5] == 6'h00,
                               pipe_width_reg[4] == 6'h00,
                               pipe_width_reg[3] == 6'h00};
  assign global_varlen_en   = proto_opts_reg[`RPC_OPT_GLOBAL_VARLEN];
  assign ack_payload_en     = proto_opts_reg[`RPC_OPT_ACK_PAYLOAD];
  assign noack_cmd_en       = proto_opts_reg[`RPC_OPT_NOACK_CMD];
  assign lna_wait_cycles    = timing_reg[39:32];
  assign bandgap_wait_count = timing_reg[31:24];
  assign rx_timeout_count   = timing_reg[23:16];
  assign tail_repeat_count  = guard_reg[7:5];
  assign preguard_enable    = guard_reg[`RPC_GRD_ENABLE];
  assign preguard_bits      = {1'b0, guard_reg[3:0]} + 5'h01;

  always @(posedge mclk) begin
    if (!reset_n) begin
      pipe_varlen_active <= 6'h00;
      noack_cmd_accept   <= 1'b0;
      noack_cmd_reject   <= 1'b0;
      chip_enable_eff    <= 1'b0;
    end else begin
      pipe_varlen_active <= varlen_en_reg & {NUM_PIPES{global_varlen_en}};
      noack_cmd_accept   <= write_payload_without_ack_cmd & noack_cmd_en;
      noack_cmd_reject   <= write_payload_without_ack_cmd & ~noack_cmd_en;
      // lets software drop chip enable while the pin is strapped high
      chip_enable_eff    <= chip_enable_pin & ~guard_reg[`RPC_GRD_CE_OVERRIDE];
    end
  end

  // ----------------------------------------
  // transition timers
  // ----------------------------------------
  wire tx_busy;
  wire rx_busy;
  wire to_busy;
  wire bg_busy;

  rpc_us_timer #(.CYC_PER_US(CYC_PER_US)) u_tx_setup (
    .mclk     (mclk),
    .reset_n  (reset_n),
    .start    (start_tx_setup),
    .count_us (timing_reg[15:8]),
    .busy     (tx_busy),
    .done     (tx_setup_done)
  );

  rpc_us_timer #(.CYC_PER_US(CYC_PER_US)) u_rx_setup (
    .mclk     (mclk),
    .reset_n  (reset_n),
    .start    (start_rx_setup),
    .count_us (timing_reg[7:0]),
    .busy     (rx_busy),
    .done     (rx_setup_done)
  );

  rpc_us_timer #(.CYC_PER_US(CYC_PER_US)) u_rx_timeout (
    .mclk     (mclk),
    .reset_n  (reset_n),
    .start    (start_rx_timeout),
    .count_us (timing_reg[23:16]),
    .busy     (to_busy),
    .done     (rx_timeout_done)
  );

  rpc_us_timer #(.CYC_PER_US(CYC_PER_US)) u_bandgap (
    .mclk     (mclk),
    .reset_n  (reset_n),
    .start    (start_bandgap_wait),
    .count_us (timing_reg[31:24]),
    .busy     (bg_busy),
    .done     (bandgap_done)
  );

  assign setup_busy = tx_busy | rx_busy | to_busy | bg_busy;

endmodule // rpc_config_regs
`default_nettype wire

// *** rpc_config_regs_sva.sv ***
// port assertions for the upper configuration register bank
`timescale 1ns/1ps
`default_nettype none
module rpc_config_regs_sva (
  // clock and reset
  input wire logic       mclk,
  input wire logic       reset_n,
  // register writes
  input wire logic [4:0] reg_addr,
  input wire logic [2:0] reg_byte,
  input wire logic       reg_wr,
  input wire logic [7:0] reg_wdata,
  // engine side
  input wire logic       write_payload_without_ack_cmd,
  input wire logic       chip_enable_pin,
  // configuration outputs
  input wire logic [5:0] pipe_varlen_active,
  input wire logic       global_varlen_en,
  input wire logic       ack_payload_en,
  input wire logic       noack_cmd_en,
  input wire logic       noack_cmd_accept,
  input wire logic       noack_cmd_reject,
  input wire logic [2:0] tail_repeat_count,
  input wire logic       preguard_enable,
  input wire logic [4:0] preguard_bits,
  input wire logic       chip_enable_eff
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);
  sequence s_opt_wr;
    reg_wr && reg_addr == 5'h1d && reg_byte == 3'h0;
  endsequence
  sequence s_grd_wr;
    reg_wr && reg_addr == 5'h1f && reg_byte == 3'h0;
  endsequence
  opts_write_a: assert property (s_opt_wr |=>
    {global_varlen_en, ack_payload_en, noack_cmd_en} == $past(reg_wdata[2:0]))
    else $error("option bits not as written");
  noack_accept_a: assert property (write_payload_without_ack_cmd && noack_cmd_en
    |=> noack_cmd_accept && !noack_cmd_reject) else $error("no-ack command not accepted");
  noack_reject_a: assert property (write_payload_without_ack_cmd && !noack_cmd_en
    |=> noack_cmd_reject && !noack_cmd_accept) else $error("no-ack command not refused");
  accept_cause_a: assert property (noack_cmd_accept |->
    $past(write_payload_without_ack_cmd) && $past(noack_cmd_en)) else $error("stray accept");
  reject_cause_a: assert property (noack_cmd_reject |->
    $past(write_payload_without_ack_cmd) && !$past(noack_cmd_en)) else $error("stray reject");
  varlen_gate_a: assert property (!global_varlen_en |=> pipe_varlen_active == 6'h00)
    else $error("pipe variable length on while globally off");
  ce_gate_a: assert property (!chip_enable_pin |=> !chip_enable_eff)
    else $error("chip enable active with pin low");
  guard_write_a: assert property (s_grd_wr |=>
    tail_repeat_count == $past(reg_wdata[7:5]) && preguard_enable == $past(reg_wdata[4])
    && preguard_bits == {1'b0, $past(reg_wdata[3:0])} + 5'd1)
    else $error("guard fields not as written");
endmodule // rpc_config_regs_sva
bind rpc_config_regs rpc_config_regs_sva chk (
  .mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_byte(reg_byte),
  .reg_wr(reg_wr), .reg_wdata(reg_wdata), .chip_enable_pin(chip_enable_pin),
  .write_payload_without_ack_cmd(write_payload_without_ack_cmd),
  .pipe_varlen_active(pipe_varlen_active), .global_varlen_en(global_varlen_en),
  .ack_payload_en(ack_payload_en), .noack_cmd_en(noack_cmd_en),
  .noack_cmd_accept(noack_cmd_accept), .noack_cmd_reject(noack_cmd_reject),
  .tail_repeat_count(tail_repeat_count), .preguard_enable(preguard_enable),
  .preguard_bits(preguard_bits), .chip_enable_eff(chip_enable_eff));
`default_nettype wire

// *** rpc_host_model.sv ***
// host model driving the byte-wide register port
`timescale 1ns/1ps
`default_nettype none
module rpc_host_model (
  // clock
  input  wire logic       mclk,
  // register port
  output var  logic [4:0] reg_addr = 5'h00,
  output var  logic [2:0] reg_byte = 3'h0,
  output var  logic       reg_wr = 1'b0,
  output var  logic [7:0] reg_wdata = 8'h00,
  output var  logic       reg_rd = 1'b0,
  input  wire logic [7:0] reg_rdata
);
  // strobes move on falling edges so each is taken at exactly one rising edge
  task automatic wr(input logic [4:0] a, input logic [2:0] b, input logic [7:0] v);
    @(negedge mclk);
    reg_addr = a;
    reg_byte = b;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
    reg_wdata = ~v;
  endtask
  task automatic rd(input logic [4:0] a, input logic [2:0] b, output logic [7:0] v);
    @(negedge mclk);
    reg_addr = a;
    reg_byte = b;
    reg_rd = 1'b1;
    @(negedge mclk);
    reg_rd = 1'b0;
    v = reg_rdata;
  endtask
endmodule // rpc_host_model
`default_nettype wire

// *** rpc_config_regs_test.sv ***
// self-checking bench for the upper configuration register bank
`timescale 1ns/1ps
`default_nettype none
module rpc_config_regs_test;
  localparam int CYC = 2;
  logic        mclk = 1'b0;
  logic        reset_n = 1'b0;
  logic [4:0]  qf = 5'h05;
  logic        cmd = 1'b0;
  logic        pin = 1'b0;
  logic [3:0]  go = 4'h0;
  logic [7:0]  d;
  int          checks = 0;
  int          miscompares = 0;
  int          cyc = 0;
  int          k;
  wire  [4:0]  addr;
  wire  [4:0]  pgb;
  wire  [2:0]  bsel;
  wire  [2:0]  tail;
  wire  [7:0]  wdata, rdata, lna, bgap, rxto;
  wire  [5:0]  active, unused, w3, w4, w5;
  wire  [3:0]  fin;
  wire         wr, rd, gen, ack, nen, acc, rej, pge, ce, busy;
  // {byte, address, reset value}
  logic [15:0] rv [16] = '{16'h1400, 16'h1500, 16'h1600, 16'h1711, 16'h1c00, 16'h1d00,
    16'h1e28, 16'h3e32, 16'h5e80, 16'h7e10, 16'h9e00, 16'hbe00, 16'h1f32, 16'h3f00,
    16'h5f00, 16'h1800};
  always #5 mclk = ~mclk;
  rpc_host_model host (.mclk(mclk), .reg_addr(addr), .reg_byte(bsel), .reg_wr(wr),
    .reg_wdata(wdata), .reg_rd(rd), .reg_rdata(rdata));
  rpc_config_regs #(.CYC_PER_US(CYC)) uut (.mclk(mclk), .reset_n(reset_n),
    .reg_addr(addr), .reg_byte(bsel), .reg_wr(wr), .reg_wdata(wdata), .reg_rd(rd),
    .reg_rdata(rdata), .tx_payload_reuse_flag(qf[4]), .tx_queue_full(qf[3]),
    .tx_queue_empty(qf[2]), .rx_queue_full(qf[1]), .rx_queue_empty(qf[0]),
    .write_payload_without_ack_cmd(cmd), .start_tx_setup(go[0]), .start_rx_setup(go[1]),
    .start_rx_timeout(go[2]), .start_bandgap_wait(go[3]), .chip_enable_pin(pin),
    .pipe3_width(w3), .pipe4_width(w4), .pipe5_width(w5), .pipe3_5_unused(unused),
    .pipe_varlen_active(active), .global_varlen_en(gen), .ack_payload_en(ack),
    .noack_cmd_en(nen), .noack_cmd_accept(acc), .noack_cmd_reject(rej),
    .lna_wait_cycles(lna), .bandgap_wait_count(bgap), .rx_timeout_count(rxto),
    .tail_repeat_count(tail), .preguard_enable(pge), .preguard_bits(pgb),
    .chip_enable_eff(ce), .tx_setup_done(fin[0]), .rx_setup_done(fin[1]),
    .rx_timeout_done(fin[2]), .bandgap_done(fin[3]), .setup_busy(busy));
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rchk(input logic [4:0] a, input logic [2:0] b, input logic [7:0] e);
    host.rd(a, b, d);
    chk("rdata", {8'h00, e}, {8'h00, d});
  endtask
  task automatic pulse;
    @(negedge mclk);
    cmd = 1'b1;
    @(negedge mclk);
    cmd = 1'b0;
  endtask
  task automatic summarize;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // a hang shows up as a count well beyond the hundred or so cycles the tests need
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      miscompares++;
      summarize();
    end
  end
  initial begin
    repeat (5) @(negedge mclk);
    reset_n = 1'b1;
    foreach (rv[i]) begin
      rchk(rv[i][12:8], rv[i][15:13], rv[i][7:0]);
    end
    host.wr(5'h14, 3'h0, 8'h20);
    host.wr(5'h15, 3'h0, 8'h21);
    rchk(5'h14, 3'h0, 8'h20);
    rchk(5'h15, 3'h0, 8'h20);
    host.wr(5'h14, 3'h0, 8'h00);
    host.wr(5'h16, 3'h0, 8'h05);
    chk("unused", 16'h0001, {10'h000, unused});
    chk("pipe3 width", 16'h0000, {10'h000, w3});
    chk("pipe4 width", 16'h0020, {10'h000, w4});
    chk("pipe5 width", 16'h0005, {10'h000, w5});
    host.wr(5'h17, 3'h0, 8'hff);
    for (int j = 0; j < 5; j++) begin
      qf = 5'(1 << j);
      rchk(5'h17, 3'h0, {1'b0, qf[4:2], 2'b00, qf[1:0]});
    end
    host.wr(5'h1c, 3'h0, 8'h3f);
    rchk(5'h1c, 3'h0, 8'h3f);
    chk("varlen off", 16'h0000, {10'h000, active});
    pulse();
    chk("noack off", 16'h0001, {14'h0000, acc, rej});
    host.wr(5'h1d, 3'h0, 8'h07);
    rchk(5'h1d, 3'h0, 8'h07);
    chk("varlen on", 16'h003f, {10'h000, active});
    chk("options", 16'h0007, {13'h0000, gen, ack, nen});
    pulse();
    chk("noack on", 16'h0002, {14'h0000, acc, rej});
    for (int i = 0; i < 4; i++) begin
      host.wr(5'h1e, 3'((i == 0) ? 1 : (i == 1) ? 0 : i), 8'(i + 1));
      go[i] = 1'b1;
      @(negedge mclk);
      go[i] = 1'b0;
      chk("busy", 16'h0001, {15'h0000, busy});
      // this negedge follows the start edge itself, so no cycle has been counted yet
      k = 0;
      while (fin[i] !== 1'b1 && k < 900) begin
        @(negedge mclk);
        k++;
      end
      chk("timer", 16'((i + 1) * CYC), 16'(k));
    end
    chk("timing", 16'h0403, {bgap, rxto});
    host.wr(5'h1e, 3'h4, 8'h5a);
    chk("lna", 16'h005a, {8'h00, lna});
    pin = 1'b1;
    @(negedge mclk);
    chk("chip enable", 16'h0001, {15'h0000, ce});
    host.wr(5'h1f, 3'h1, 8'h80);
    @(negedge mclk);
    chk("chip enable", 16'h0000, {15'h0000, ce});
    host.wr(5'h1f, 3'h0, 8'hff);
    chk("guard", 16'h01f0, {7'h00, tail, pge, pgb});
    host.wr(5'h1f, 3'h0, 8'h00);
    chk("guard", 16'h0001, {7'h00, tail, pge, pgb});
    summarize();
  end
endmodule // rpc_config_regs_test
`default_nettype wire
